// *** src/lictl2_defs.svh ***
// Constants for the line control two register bank: offsets, fields, resets.
// Assumes inclusion by bare name from the design and testbench files.
`ifndef LICTL2_DEFS_SVH
`define LICTL2_DEFS_SVH

// Register offsets (byte addresses on the plain register port)
`define LICTL2_OFS_CTRL2     8'h11
`define LICTL2_OFS_IRQ_STAT  8'h40
`define LICTL2_OFS_IRQ_MASK  8'h41
`define LICTL2_OFS_CTRL1     8'h42

// Field positions in line_control_two
`define LICTL2_BIT_CAL_CLR   7
`define LICTL2_BIT_MANUAL_CALIBRATION_START      6
`define LICTL2_BIT_AUTO_CALIBRATION_DISABLE      5
`define LICTL2_BIT_RT_HI     4
`define LICTL2_BIT_OPE       3
`define LICTL2_BIT_BTE       2
`define LICTL2_BIT_ROV       1
`define LICTL2_BIT_BTD       0

// Mirrored receive overload interrupt bit position
`define LICTL2_BIT_RECEIVE_OVERLOAD_IRQ_FLAG      6

// Interrupt status bit positions
`define LICTL2_IRQ_ROV       0
`define LICTL2_IRQ_BTD       1
`define LICTL2_IRQ_RECEIVE_OVERLOAD_IRQ_FLAG      2

// Reset values
`define LICTL2_RST_CTRL2     8'h00
`define LICTL2_RST_IRQ       8'h00
`define LICTL2_RST_CTRL1     8'h00

// Debounce: events must persist one cycle longer than this count
`define LICTL2_EVT_FILT      4

`endif

// *** src/lictl2_pkg.sv ***
// Types shared by the line control two register bank.
// Assumes the defs header is on the include path.
package lictl2_pkg;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } lictl2_req_t;

  // Calibration, ring detect, overload and billing tone controls toward the analog front end
  typedef struct packed {
    logic       cal_clear;
    logic       cal_start;
    logic       auto_cal_en;
    logic [1:0] ring_thresh;
    logic       overload_protect;
    logic       billing_hold;
  } lictl2_ctl_t;

  // Ring threshold pair select
  typedef enum logic [1:0] {
    LICTL2_RT_LOW  = 2'h0,
    LICTL2_RT_RSVD = 2'h1,
    LICTL2_RT_MID  = 2'h2,
    LICTL2_RT_HIGH = 2'h3
  } lictl2_rt_t;

endpackage

// *** src/lictl2_evt_filt.sv ***
// Event qualifier: passes a level once stable for a count of cycles.
// Assumes the input is synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module lictl2_evt_filt #(
  parameter int CNT = 4
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // Event
  input  wire logic raw,
  output logic      hit
);
  localparam int W = $clog2(CNT + 1);

  // Refuse a zero length filter
  if (CNT < 1) begin : g_chk
    $error("CNT must be at least one");
  end

  logic [W-1:0] cnt_r;  // Stable run length

  // Count consecutive high cycles, saturating
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      if (!raw) begin
        cnt_r <= '0;
      end else if (cnt_r != W'(CNT)) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // Qualified while the run is long enough
  assign hit = raw && (cnt_r == W'(CNT));
endmodule
`default_nettype wire

// *** src/lictl2_reg_port.sv ***
// Plain register port slave: decodes strobes, registers read data.
// Assumes one-cycle strobes from a master on ref_clk, never both at once.
`timescale 1ns/1ns
`default_nettype none
module lictl2_reg_port
  import lictl2_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Bus request
  input  wire lictl2_req_t req,
  // Register read values
  input  wire logic [7:0]  ctrl2_val,
  input  wire logic [7:0]  stat_val,
  input  wire logic [7:0]  mask_val,
  input  wire logic [7:0]  ctrl1_val,
  // Decoded writes
  output logic             wr_ctrl2,
  output logic             wr_stat,
  output logic             wr_mask,
  output logic             wr_ctrl1,
  // Read data, one cycle after the strobe
  output logic [7:0]       rdata
);
`include "lictl2_defs.svh"

  logic [7:0] mux;  // Combinational read selection

  // Write decode
  assign wr_ctrl2 = req.wr && (req.addr == `LICTL2_OFS_CTRL2);
  assign wr_stat  = req.wr && (req.addr == `LICTL2_OFS_IRQ_STAT);
  assign wr_mask  = req.wr && (req.addr == `LICTL2_OFS_IRQ_MASK);
  assign wr_ctrl1 = req.wr && (req.addr == `LICTL2_OFS_CTRL1);

  // Read selection; unmapped reads as zero
  always_comb begin
    case (req.addr)
      `LICTL2_OFS_CTRL2:    mux = ctrl2_val;
      `LICTL2_OFS_IRQ_STAT: mux = stat_val;
      `LICTL2_OFS_IRQ_MASK: mux = mask_val;
      `LICTL2_OFS_CTRL1:    mux = ctrl1_val;
      default:              mux = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 8'h00;
    end else if (clk_en) begin
      rdata <= req.rd ? mux : 8'h00;
    end
  end
endmodule
`default_nettype wire

// *** src/lictl2_top.sv ***
// Line control two register bank: calibration, ring threshold, overload
// and billing tone control with sticky event flags and an interrupt.
// Assumes event inputs synchronous to ref_clk and a plain register port.
`timescale 1ns/1ns
`default_nettype none
`include "lictl2_defs.svh"
module lictl2_top
  import lictl2_pkg::*;
#(
  parameter int EVT_FILT = `LICTL2_EVT_FILT
) (
  // Clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // Line side events
  input  wire logic        supply_disrupt,
  input  wire logic        rx_below_ground,
  input  wire logic        off_hook,
  // Calibration engine handshake
  input  wire logic        cal_busy,
  // Controls to front end
  output lictl2_ctl_t      ctl,
  output logic             hold_off_hook,
  output logic             receive_overload_irq_flag,
  // Interrupt
  output logic             irq
);

  // Refuse a filter length the counter cannot serve
  if (EVT_FILT < 1 || EVT_FILT > 255) begin : g_chk
    $error("EVT_FILT out of range");
  end

  // Register fields
  logic       calibration_clear_r;        // Clear request held by software
  logic       manual_calibration_start_r; // Manual start bit
  logic       auto_calibration_disable_r; // Auto calibration off
  logic       ring_threshold_high_select_r; // Second threshold bit
  logic       overload_protect_enable_r;  // Overload protection
  logic       billing_tone_enable_r;      // Ride-through enable
  logic       billing_tone_detected_r;    // Sticky detection
  logic       receive_overload_flag_r;    // Sticky overload
  logic       ring_threshold_low_select_r; // Companion bit, other register
  logic       receive_overload_irq_flag_r;                     // Mirrored interrupt flag
  logic [7:0] stat_r;                     // Interrupt status
  logic [7:0] mask_r;                     // Interrupt mask
  logic       cal_start_r;                // One-cycle start pulse

  // Decode
  lictl2_req_t req;
  logic        wr_ctrl2;
  logic        wr_stat;
  logic        wr_mask;
  logic        wr_ctrl1;
  logic        bt_hit;
  logic        rov_hit;
  logic        bt_evt;
  logic        rov_evt;
  logic [7:0]  ctrl2_val;
  logic [7:0]  ctrl1_val;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Register port
  lictl2_reg_port u_port (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .req       (req),
    .ctrl2_val (ctrl2_val),
    .stat_val  (stat_r),
    .mask_val  (mask_r),
    .ctrl1_val (ctrl1_val),
    .wr_ctrl2  (wr_ctrl2),
    .wr_stat   (wr_stat),
    .wr_mask   (wr_mask),
    .wr_ctrl1  (wr_ctrl1),
    .rdata     (reg_rdata)
  );

  // Event qualifiers reject single-cycle glitches
  lictl2_evt_filt #(.CNT(EVT_FILT)) u_bt_filt (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .raw     (supply_disrupt),
    .hit     (bt_hit)
  );

  lictl2_evt_filt #(.CNT(EVT_FILT)) u_rov_filt (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .raw     (rx_below_ground),
    .hit     (rov_hit)
  );

  // Billing detection only counts while enabled and off-hook
  assign bt_evt  = bt_hit && billing_tone_enable_r && off_hook;
  assign rov_evt = rov_hit;

  // Read image of the control register
  assign ctrl2_val = {calibration_clear_r, manual_calibration_start_r,
                      auto_calibration_disable_r, ring_threshold_high_select_r,
                      overload_protect_enable_r, billing_tone_enable_r,
                      receive_overload_flag_r, billing_tone_detected_r};
  assign ctrl1_val = {7'h00, ring_threshold_low_select_r};

  // Plain control bits; clear bit stays until software rewrites it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      calibration_clear_r          <= 1'b0;
      auto_calibration_disable_r   <= 1'b0;
      ring_threshold_high_select_r <= 1'b0;
      overload_protect_enable_r    <= 1'b0;
      billing_tone_enable_r        <= 1'b0;
    end else if (clk_en && wr_ctrl2) begin
      calibration_clear_r          <= reg_wdata[`LICTL2_BIT_CAL_CLR];
      auto_calibration_disable_r   <= reg_wdata[`LICTL2_BIT_AUTO_CALIBRATION_DISABLE];
      ring_threshold_high_select_r <= reg_wdata[`LICTL2_BIT_RT_HI];
      overload_protect_enable_r    <= reg_wdata[`LICTL2_BIT_OPE];
      billing_tone_enable_r        <= reg_wdata[`LICTL2_BIT_BTE];
    end
  end

  // Companion threshold bit in the other control register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ring_threshold_low_select_r <= 1'b0;
    end else if (clk_en && wr_ctrl1) begin
      ring_threshold_low_select_r <= reg_wdata[0];
    end
  end

  // Manual calibration: bit reads back set until the engine finishes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      manual_calibration_start_r <= 1'b0;
      cal_start_r                <= 1'b0;
    end else if (clk_en) begin
      cal_start_r <= wr_ctrl2 && reg_wdata[`LICTL2_BIT_MANUAL_CALIBRATION_START];
      if (wr_ctrl2) begin
        manual_calibration_start_r <= reg_wdata[`LICTL2_BIT_MANUAL_CALIBRATION_START];
      end else if (manual_calibration_start_r && !cal_start_r && !cal_busy) begin
        // Self-clears once the engine goes idle
        manual_calibration_start_r <= 1'b0;
      end
    end
  end

  // Billing detected flag: set wins over clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      billing_tone_detected_r <= 1'b0;
    end else if (clk_en) begin
      if (bt_evt) begin
        billing_tone_detected_r <= 1'b1;
      end else if (wr_ctrl2 && !reg_wdata[`LICTL2_BIT_BTE]) begin
        billing_tone_detected_r <= 1'b0;
      end
    end
  end

  // Receive overload and mirrored interrupt flag
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      receive_overload_flag_r <= 1'b0;
      receive_overload_irq_flag_r                  <= 1'b0;
    end else if (clk_en) begin
      if (rov_evt) begin
        receive_overload_flag_r <= 1'b1;
        receive_overload_irq_flag_r                  <= 1'b1;
      end else if (wr_ctrl2 && !reg_wdata[`LICTL2_BIT_ROV]) begin
        receive_overload_flag_r <= 1'b0;
        receive_overload_irq_flag_r                  <= 1'b0;
      end
    end
  end

  // Interrupt status, write one to clear, events win
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_r <= `LICTL2_RST_IRQ;
    end else if (clk_en) begin
      for (int i = 0; i < 8; i++) begin
        if (wr_stat && reg_wdata[i]) begin
          stat_r[i] <= 1'b0;
        end
      end
      if (rov_evt) begin
        stat_r[`LICTL2_IRQ_ROV] <= 1'b1;
      end
      if (bt_evt) begin
        stat_r[`LICTL2_IRQ_BTD] <= 1'b1;
      end
      if (rov_evt && !receive_overload_flag_r) begin
        stat_r[`LICTL2_IRQ_RECEIVE_OVERLOAD_IRQ_FLAG] <= 1'b1;
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_r <= `LICTL2_RST_IRQ;
    end else if (clk_en && wr_mask) begin
      mask_r <= reg_wdata;
    end
  end

  // Outputs to the front end
  assign ctl.cal_clear        = calibration_clear_r;
  assign ctl.cal_start        = cal_start_r;
  assign ctl.auto_cal_en      = !auto_calibration_disable_r;
  // Reserved code 01 is passed as is; software must avoid it
  assign ctl.ring_thresh      = {ring_threshold_low_select_r,
                                 ring_threshold_high_select_r};
  assign ctl.overload_protect = overload_protect_enable_r;
  assign ctl.billing_hold     = billing_tone_enable_r;
  assign hold_off_hook        = billing_tone_enable_r && off_hook;
  assign receive_overload_irq_flag = receive_overload_irq_flag_r;
  assign irq                  = |(stat_r & mask_r);
endmodule
`default_nettype wire

// *** testbench/lictl2_top_checker.sv ***
// Port-level checker for the line control two register bank.
// Assumes binding onto lictl2_top; one clock domain.
`timescale 1ns/1ns
`default_nettype none
`include "lictl2_defs.svh"
module lictl2_top_checker
  import lictl2_pkg::*;
#(
  parameter int EVT_FILT = 4
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Line side and outputs
  input wire logic        supply_disrupt,
  input wire logic        rx_below_ground,
  input wire logic        off_hook,
  input wire logic        cal_busy,
  input wire lictl2_ctl_t ctl,
  input wire logic        hold_off_hook,
  input wire logic        receive_overload_irq_flag,
  input wire logic        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Control register write taken at this edge
  wire logic wr2 = clk_en && reg_wr && reg_addr == `LICTL2_OFS_CTRL2;
  wire logic wrm = clk_en && reg_wr && reg_addr == `LICTL2_OFS_IRQ_MASK;

  a_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_clear_bit_follows: assert property (wr2 |=> ctl.cal_clear == $past(reg_wdata[7]))
    else $error("calibration clear does not follow write");
  a_start_one_pulse: assert property (wr2 && reg_wdata[6] && !ctl.cal_start |=> ctl.cal_start ##1 !ctl.cal_start)
    else $error("calibration start not a single pulse");
  a_auto_cal_inverted: assert property (wr2 |=> ctl.auto_cal_en != $past(reg_wdata[5]))
    else $error("auto calibration enable not inverse of bit");
  a_ring_high_sel: assert property (wr2 |=> ctl.ring_thresh[0] == $past(reg_wdata[4]))
    else $error("ring high select does not follow write");
  a_hold_when_on: assert property ((ctl.billing_hold && off_hook) [*2] |-> hold_off_hook)
    else $error("off-hook hold missing");
  a_hold_when_off: assert property ((!ctl.billing_hold) [*2] |-> !hold_off_hook)
    else $error("off-hook hold without billing enable");
  a_mirror_sticky: assert property (receive_overload_irq_flag && !reg_wr |=> receive_overload_irq_flag)
    else $error("overload mirror dropped without a write");
  a_overload_clear: assert property ((!rx_below_ground) [*3] ##0 (wr2 && !reg_wdata[1]) |=> !receive_overload_irq_flag)
    else $error("overload mirror not cleared by write");
  a_mask_quiets: assert property (wrm && reg_wdata == 8'h00 |=> ##1 !irq)
    else $error("interrupt high with all sources masked");

  // Main scenarios reached
  c_cal_start: cover property (wr2 && reg_wdata[6]);
  c_overload: cover property ($rose(receive_overload_irq_flag));
  c_hold: cover property (hold_off_hook);
endmodule

bind lictl2_top lictl2_top_checker #(.EVT_FILT(EVT_FILT)) lictl2_top_checker_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .supply_disrupt(supply_disrupt), .rx_below_ground(rx_below_ground),
  .off_hook(off_hook), .cal_busy(cal_busy), .ctl(ctl), .hold_off_hook(hold_off_hook),
  .receive_overload_irq_flag(receive_overload_irq_flag), .irq(irq)
);
`default_nettype wire

// *** testbench/lictl2_top_bench.sv ***
// Self-checking bench for the line control two register bank.
// Assumes package and defs header compiled first; clock enable held on except for the frozen write check.
`timescale 1ns/1ns
`default_nettype none
`include "lictl2_defs.svh"
module lictl2_top_bench;
  import lictl2_pkg::*;
  // Stimulus
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        sup_dis = 1'b0;
  logic        rx_low = 1'b0;
  logic        off_hook = 1'b0;
  logic        cal_busy = 1'b0;
  // Observed
  logic [7:0]  reg_rdata;
  lictl2_ctl_t ctl;
  logic        hold;
  logic        rov_irq;
  logic        irq;
  // Score and watchdog
  int          n_fail = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [7:0]  v;

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  // Short filter keeps event tests brief
  lictl2_top #(.EVT_FILT(1)) lictl2_top_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .supply_disrupt(sup_dis), .rx_below_ground(rx_low), .off_hook(off_hook),
    .cal_busy(cal_busy), .ctl(ctl), .hold_off_hook(hold),
    .receive_overload_irq_flag(rov_irq), .irq(irq)
  );

  // Compare and report
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, far above the hundred or so cycles needed
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // One-cycle write; returns mid-cycle after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(negedge ref_clk);
  endtask

  // One-cycle read; data sampled in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    rd(a, v);
    check(v, exp, "read");
  endtask

  // Event input high for a few cycles, then settle
  task automatic pulse(input bit ovl);
    @(posedge ref_clk);
    if (ovl) begin
      rx_low <= 1'b1;
    end else begin
      sup_dis <= 1'b1;
    end
    repeat (3) @(posedge ref_clk);
    rx_low <= 1'b0;
    sup_dis <= 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask

  // Reset values, unmapped place ignored
  task automatic t_reset();
    @(negedge ref_clk);
    check(8'(ctl), 8'h10, "ctl reset");
    rdc(`LICTL2_OFS_CTRL2, 8'h00);
    rdc(`LICTL2_OFS_IRQ_STAT, 8'h00);
    rdc(`LICTL2_OFS_IRQ_MASK, 8'h00);
    wr(8'h33, 8'hFF);
    rdc(8'h33, 8'h00);
  endtask

  // Writable fields except manual start and overload, read-only detected bit
  task automatic t_fields();
    wr(`LICTL2_OFS_CTRL2, 8'hBD);
    rdc(`LICTL2_OFS_CTRL2, 8'hBC);
    check(8'(ctl.cal_clear), 8'h01, "clear");
    check(8'(ctl.auto_cal_en), 8'h00, "auto cal");
    check(8'(ctl.overload_protect), 8'h01, "protect");
    wr(`LICTL2_OFS_CTRL2, 8'h3C);
    check(8'(ctl.cal_clear), 8'h00, "clear back");
    wr(`LICTL2_OFS_CTRL2, 8'h00);
    check(8'(ctl.auto_cal_en), 8'h01, "auto cal");
    // Frozen clock enable must swallow a write
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(`LICTL2_OFS_CTRL2, 8'h08);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    @(negedge ref_clk);
    check(8'(ctl.overload_protect), 8'h00, "frozen");
  endtask

  // Three legal threshold pairs checked; reserved code 01 appears briefly during the final restore
  task automatic t_ring();
    logic [1:0] codes [3];
    codes = '{2'b00, 2'b10, 2'b11};
    for (int i = 0; i < 3; i++) begin
      wr(`LICTL2_OFS_CTRL1, {7'h00, codes[i][1]});
      wr(`LICTL2_OFS_CTRL2, {3'h0, codes[i][0], 4'h0});
      check(8'(ctl.ring_thresh), 8'(codes[i]), "ring");
    end
    wr(`LICTL2_OFS_CTRL1, 8'h00);
    wr(`LICTL2_OFS_CTRL2, 8'h00);
  endtask

  // Manual calibration start while the engine is busy
  task automatic t_cal();
    @(posedge ref_clk);
    cal_busy <= 1'b1;
    wr(`LICTL2_OFS_CTRL2, 8'h40);
    check(8'(ctl.cal_start), 8'h01, "start");
    rdc(`LICTL2_OFS_CTRL2, 8'h40);
    @(posedge ref_clk);
    cal_busy <= 1'b0;
    repeat (3) @(negedge ref_clk);
    rdc(`LICTL2_OFS_CTRL2, 8'h00);
  endtask

  // Billing tone hold, sticky flag, clear by enable low
  task automatic t_bill();
    wr(`LICTL2_OFS_CTRL2, 8'h04);
    @(posedge ref_clk);
    off_hook <= 1'b1;
    @(negedge ref_clk);
    check(8'(hold), 8'h01, "hold");
    check(8'(ctl.billing_hold), 8'h01, "billing hold");
    pulse(1'b0);
    rdc(`LICTL2_OFS_CTRL2, 8'h05);
    check(8'(hold), 8'h01, "hold");
    wr(`LICTL2_OFS_CTRL2, 8'h04);
    rdc(`LICTL2_OFS_CTRL2, 8'h05);
    rdc(`LICTL2_OFS_IRQ_STAT, 8'h02);
    wr(`LICTL2_OFS_CTRL2, 8'h00);
    rdc(`LICTL2_OFS_CTRL2, 8'h00);
    check(8'(hold), 8'h00, "hold");
    check(8'(ctl.billing_hold), 8'h00, "billing hold");
    wr(`LICTL2_OFS_IRQ_STAT, 8'hFF);
    @(posedge ref_clk);
    off_hook <= 1'b0;
  endtask

  // Receive overload flag, mirror and interrupt masking
  task automatic t_rov();
    wr(`LICTL2_OFS_IRQ_MASK, 8'h01);
    pulse(1'b1);
    rdc(`LICTL2_OFS_CTRL2, 8'h02);
    check(8'(rov_irq), 8'h01, "mirror");
    check(8'(irq), 8'h01, "irq");
    rdc(`LICTL2_OFS_IRQ_STAT, 8'h05);
    wr(`LICTL2_OFS_IRQ_MASK, 8'h00);
    @(negedge ref_clk);
    check(8'(irq), 8'h00, "irq masked");
    wr(`LICTL2_OFS_IRQ_STAT, 8'hFF);
    rdc(`LICTL2_OFS_IRQ_STAT, 8'h00);
    wr(`LICTL2_OFS_CTRL2, 8'h00);
    check(8'(rov_irq), 8'h00, "mirror clear");
    rdc(`LICTL2_OFS_CTRL2, 8'h00);
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_fields();
    t_ring();
    t_cal();
    t_bill();
    t_rov();
    tally_and_finish();
  end
endmodule
`default_nettype wire
